// *** verilog/trace_map.svh ***
// constants of the trace packet framer: header codes, field positions, timing counts
// assumes a 50 MHz ref_clk and is included by bare name
`ifndef TRACE_MAP_SVH
`define TRACE_MAP_SVH
`define HDR_SYNC        8'h00
`define SYNC_TAIL       8'h80
`define SYNC_LEN        3'h7
`define HDR_OVF         8'h70
`define HDR_LTS_LONG    8'hC0
`define TC_LSB          4
`define CONT_BIT        7
`define DELTA_W         28
`define SHORT_MIN       28'h0000001
`define SHORT_MAX       28'h0000006
`define SYNC_ZERO_BITS  6'h2F
`define MAX_PKT_LEN     3'h7
`define CLK_PERIOD_NS   20
`define SYNC_PERIOD_US  80
`define SYNC_PERIOD_CYC ((`SYNC_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define SRC_FIFO_DEPTH  4
`define SRC_WORD_W      40
`endif

// *** verilog/trace_pkg.sv ***
// types shared by both ends of the trace byte link
// assumes trace_map.svh is on the include path
`include "trace_map.svh"
package trace_pkg;
  typedef enum logic [1:0] {IDLE = 2'b01, SEND = 2'b10} fsm_t;
  typedef struct packed {
    logic [5:0]  addr;
    logic [1:0]  ss;
    logic [31:0] data;
  } src_t;
  typedef struct packed {
    logic [6:0][7:0] b;
    logic [2:0]      len;
  } pkt_t;

  // payload byte count of a source packet from its size code
  function automatic logic [2:0] src_bytes(input logic [1:0] ss);
    unique case (ss)
      2'b01:   src_bytes = 3'h1;
      2'b10:   src_bytes = 3'h2;
      2'b11:   src_bytes = 3'h4;
      default: src_bytes = 3'h0;
    endcase
  endfunction : src_bytes
endpackage : trace_pkg

// *** verilog/trace_link_if.sv ***
// byte and bit stream between the framer and a trace sink
// assumes both ends share ref_clk; serial_sel picks which path carries data
`timescale 1ns/1ns
interface trace_link_if;
  logic [7:0] byte_data;
  logic       byte_valid;
  logic       byte_ready;
  logic       bit_data;
  logic       bit_valid;
  logic       bit_ready;
  logic       serial_sel;
  modport framer_end (output byte_data, output byte_valid, output bit_data,
                      output bit_valid, output serial_sel,
                      input byte_ready, input bit_ready);
  modport sink_end   (input byte_data, input byte_valid, input bit_data,
                      input bit_valid, input serial_sel,
                      output byte_ready, output bit_ready);
endinterface : trace_link_if

// *** verilog/src_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
// assumes a single clock; clk_en low freezes it
`timescale 1ns/1ns
module src_fifo #(
  parameter int W = 40,
  parameter int D = 4
) (
  input  logic         ref_clk,
  input  logic         rst,
  input  logic         clk_en,
  input  logic [W-1:0] in_data,
  input  logic         in_valid,
  output logic         in_ready,
  output logic [W-1:0] out_data,
  output logic         out_valid,
  input  logic         out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         cnt;
    logic [AW-1:0]       rd;
  } fifo_t;
  fifo_t q, d;
  logic push, pop;
  logic [AW-1:0] wr;

  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];

  always_comb begin
    d    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    wr   = AW'(q.rd + AW'(q.cnt));
    if (push) begin
      d.mem[wr] = in_data;
    end
    if (pop) begin
      d.rd = AW'(q.rd + 1'b1);
    end
    d.cnt = (AW+1)'(q.cnt + {AW'(0), push} - {AW'(0), pop});
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end
endmodule : src_fifo

// *** verilog/trace_packet_framer.sv ***
// trace packet framer: merges stimulus and watchpoint packets with sync,
// overflow and local timestamp packets into one byte or bit stream.
// assumes a sink on trace_link_if on the same ref_clk; serial_mode selects bit path.
`timescale 1ns/1ns
`include "trace_map.svh"
module trace_packet_framer (
  input  logic                 ref_clk,
  input  logic                 rst,
  input  logic                 clk_en,
  trace_link_if.framer_end     link,
  input  logic                 serial_mode,
  input  logic                 sync_en,
  input  logic                 ts_en,
  input  logic                 stim_valid,
  input  logic [4:0]           stim_port,
  input  logic [1:0]           stim_size,
  input  logic [31:0]          stim_data,
  output logic                 stim_ready,
  input  logic                 page_wr,
  input  logic [2:0]           page_val,
  output logic [2:0]           page,
  input  logic                 wp_valid,
  input  logic [4:0]           wp_addr,
  input  logic [1:0]           wp_size,
  input  logic [31:0]          wp_data,
  output logic                 wp_busy,
  output logic                 overflow_sent,
  output logic                 busy
);
  typedef struct packed {
    trace_pkg::fsm_t     st;
    trace_pkg::pkt_t     pkt;
    logic [2:0]          idx;
    logic [2:0]          bitn;
    logic [27:0]         ts;
    logic [27:0]         ts_cap;
    logic                ts_pend;
    logic                ovf_pend;
    logic                late;
    logic [11:0]         sync_cnt;
    logic                sync_pend;
    logic                wp_full;
    trace_pkg::src_t     wp;
    logic [2:0]          page;
    logic                ovf_sent;
  } framer_t;

  framer_t q, d;
  trace_pkg::src_t stim_word;
  trace_pkg::src_t fifo_word;
  logic            fifo_valid;
  logic            fifo_pop;
  logic            adv;
  logic            sync_on;

  // source header: port in the upper bits, size code in the two low bits
  assign stim_word = '{addr: {1'b0, stim_port}, ss: stim_size, data: stim_data};

  // the buffer absorbs bursts of stimulus writes while a packet is on the link
  src_fifo #(
    .W (`SRC_WORD_W),
    .D (`SRC_FIFO_DEPTH)
  ) src_fifo_inst (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_data   (stim_word),
    .in_valid  (stim_valid),
    .in_ready  (stim_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  function automatic trace_pkg::pkt_t src_pkt(input trace_pkg::src_t w);
    trace_pkg::pkt_t p;
    p          = '0;
    p.b[0]     = {w.addr, w.ss};
    p.b[1]     = w.data[7:0];
    p.b[2]     = w.data[15:8];
    p.b[3]     = w.data[23:16];
    p.b[4]     = w.data[31:24];
    p.len      = 3'(trace_pkg::src_bytes(w.ss) + 3'h1);
    return p;
  endfunction : src_pkt

  // delta timestamp packet; short form only for synchronous deltas 1..6
  function automatic trace_pkg::pkt_t lts_pkt(input logic [27:0] dv, input logic [1:0] tc);
    trace_pkg::pkt_t p;
    logic [2:0]      k;
    p = '0;
    if (tc == 2'b00 && dv >= `SHORT_MIN && dv <= `SHORT_MAX) begin
      p.b[0] = {1'b0, dv[2:0], 4'h0};
      p.len  = 3'h1;
    end else begin
      if (dv[27:7] == '0) begin
        k = 3'h1;
      end else if (dv[27:14] == '0) begin
        k = 3'h2;
      end else if (dv[27:21] == '0) begin
        k = 3'h3;
      end else begin
        k = 3'h4;
      end
      p.b[0] = `HDR_LTS_LONG | {2'b00, tc, 4'h0};
      for (int i = 1; i <= 4; i++) begin
        p.b[i] = {(3'(i) < k), dv[7*(i-1) +: 7]};
      end
      p.len = 3'(k + 3'h1);
    end
    return p;
  endfunction : lts_pkt

  // zero header, five zero payload bytes, then 8'h80: 55 zeros and the one bit
  function automatic trace_pkg::pkt_t sync_pkt();
    trace_pkg::pkt_t p;
    p      = '0;
    p.b[0] = `HDR_SYNC;
    p.b[6] = `SYNC_TAIL;
    p.len  = `SYNC_LEN;
    return p;
  endfunction : sync_pkt

  assign sync_on = !serial_mode || sync_en;

  always_comb begin
    d        = q;
    adv      = 1'b0;
    fifo_pop = 1'b0;
    d.ovf_sent = 1'b0;
    // output side: one byte or one bit per accepted beat
    if (q.st == trace_pkg::SEND) begin
      if (serial_mode) begin
        if (link.bit_ready) begin
          d.bitn = 3'(q.bitn + 3'h1);
          adv    = (q.bitn == 3'h7);
        end
      end else begin
        adv = link.byte_ready;
      end
      if (adv) begin
        d.idx = 3'(q.idx + 3'h1);
        if (q.idx == 3'(q.pkt.len - 3'h1)) begin
          // wrap here so the byte index never leaves the seven-byte buffer
          d.idx = '0;
          d.st  = trace_pkg::IDLE;
        end
      end
    end
    // free-running delta counter
    d.ts = 28'(q.ts + 28'h1);
    // periodic sync request
    if (sync_on) begin
      if (q.sync_cnt == '0) begin
        d.sync_cnt  = 12'(`SYNC_PERIOD_CYC - 1);
        d.sync_pend = 1'b1;
      end else begin
        d.sync_cnt = 12'(q.sync_cnt - 12'h1);
      end
    end
    if (page_wr) begin
      d.page = page_val;
    end
    // arbitration, highest first: sync, overflow, timestamp, watchpoint, stimulus
    if (q.st == trace_pkg::IDLE) begin
      d.idx  = '0;
      d.bitn = '0;
      if (q.sync_pend) begin
        d.pkt       = sync_pkt();
        d.sync_pend = 1'b0;
        d.page      = '0;
        d.st        = trace_pkg::SEND;
      end else if (q.ovf_pend) begin
        d.pkt       = '0;
        d.pkt.b[0]  = `HDR_OVF;
        d.pkt.len   = 3'h1;
        d.ovf_pend  = 1'b0;
        d.late      = 1'b1;
        d.ovf_sent  = 1'b1;
        d.st        = trace_pkg::SEND;
      end else if (q.ts_pend) begin
        d.pkt     = lts_pkt(q.ts_cap, {q.late, 1'b0});
        d.ts_pend = 1'b0;
        d.late    = 1'b0;
        d.st      = trace_pkg::SEND;
      end else if (q.wp_full || fifo_valid) begin
        if (q.wp_full) begin
          d.pkt     = src_pkt(q.wp);
          d.wp_full = 1'b0;
        end else begin
          d.pkt    = src_pkt(fifo_word);
          fifo_pop = 1'b1;
        end
        if (ts_en) begin
          // capture at data time, then restart so the next value is a delta
          d.ts_cap  = q.ts;
          d.ts_pend = 1'b1;
          d.ts      = '0;
        end
        d.st = trace_pkg::SEND;
      end
    end
    // event sets come after the clears so a same-cycle event is kept
    if (wp_valid) begin
      if (d.wp_full) begin
        d.ovf_pend = 1'b1;
      end else begin
        d.wp      = '{addr: {1'b1, wp_addr}, ss: wp_size, data: wp_data};
        d.wp_full = 1'b1;
      end
    end
    if (stim_valid && !stim_ready) begin
      d.ovf_pend = 1'b1;
    end
    if (&q.ts) begin
      d.ovf_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q    <= '0;
      q.st <= trace_pkg::IDLE;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // same bytes on both paths; only the carrier differs
  assign link.serial_sel = serial_mode;
  assign link.byte_data  = q.pkt.b[q.idx];
  assign link.byte_valid = (q.st == trace_pkg::SEND) && !serial_mode;
  assign link.bit_data   = q.pkt.b[q.idx][q.bitn];
  assign link.bit_valid  = (q.st == trace_pkg::SEND) && serial_mode;
  assign page            = q.page;
  assign wp_busy         = q.wp_full;
  assign overflow_sent   = q.ovf_sent;
  assign busy            = (q.st == trace_pkg::SEND);
endmodule : trace_packet_framer

// *** verilog/trace_sink_end.sv ***
// trace sink end: takes bytes or bits from the link, rebuilds bytes lsb first,
// marks packet headers and reports sync patterns. assumes the framer on ref_clk.
`timescale 1ns/1ns
`include "trace_map.svh"
module trace_sink_end (
  input  logic          ref_clk,
  input  logic          rst,
  input  logic          clk_en,
  trace_link_if.sink_end link,
  output logic [7:0]    rx_data,
  output logic          rx_valid,
  input  logic          rx_ready,
  output logic          rx_head,
  output logic          sync_seen
);
  typedef struct packed {
    logic [7:0] data;
    logic       full;
    logic       head;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [5:0] zeros;
    logic       sync;
    logic [2:0] rem;
    logic       cont;
    logic [2:0] cnt;
    logic       in_sync;
  } sink_t;
  sink_t      q, d;
  logic       got;
  logic [7:0] b;

  always_comb begin
    d      = q;
    d.sync = 1'b0;
    got    = 1'b0;
    b      = link.byte_data;
    if (q.full && rx_ready) begin
      d.full = 1'b0;
    end
    if (link.serial_sel) begin
      if (link.bit_valid && !q.full) begin
        d.sh   = {link.bit_data, q.sh[7:1]};
        d.bitn = 3'(q.bitn + 3'h1);
        b      = d.sh;
        got    = (q.bitn == 3'h7);
        if (link.bit_data && q.zeros >= `SYNC_ZERO_BITS) begin
          d.sync = 1'b1;
        end
        d.zeros = link.bit_data ? '0 : ((&q.zeros) ? q.zeros : 6'(q.zeros + 6'h1));
      end
    end else if (link.byte_valid && !q.full) begin
      got = 1'b1;
      if (b != 8'h00 && q.zeros >= 6'(`SYNC_ZERO_BITS - 6'h7 + 6'(7 - $clog2(b + 1)))) begin
        d.sync = b[$clog2(b + 1) - 1] && (b & (b - 1)) == 8'h00;
      end
      d.zeros = (b == 8'h00) ? ((q.zeros > 6'h37) ? q.zeros : 6'(q.zeros + 6'h8)) : '0;
    end
    if (got) begin
      d.data = b;
      d.full = 1'b1;
      d.head = 1'b0;
      if (q.in_sync) begin
        d.in_sync = (b == 8'h00);
      end else if (q.rem != '0) begin
        d.rem = 3'(q.rem - 3'h1);
      end else if (q.cont) begin
        d.cnt  = 3'(q.cnt + 3'h1);
        d.cont = b[`CONT_BIT] && (d.cnt != 3'(`MAX_PKT_LEN - 3'h1));
      end else begin
        d.head = 1'b1;
        d.cnt  = '0;
        if (b == `HDR_SYNC) begin
          d.in_sync = 1'b1;
        end else if (b[1:0] == 2'b00) begin
          d.cont = b[`CONT_BIT];
        end else begin
          d.rem = trace_pkg::src_bytes(b[1:0]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign link.byte_ready = !q.full && !link.serial_sel;
  assign link.bit_ready  = !q.full && link.serial_sel;
  assign rx_data         = q.data;
  assign rx_valid        = q.full;
  assign rx_head         = q.head;
  assign sync_seen       = q.sync;
endmodule : trace_sink_end

// *** verif/trace_link_chk.sv ***
// checker for the framer-to-sink link: handshake, packet framing, header codes
// assumes a single ref_clk domain and the link signals passed as plain inputs
`timescale 1ns/1ns
module trace_link_chk (
  input logic       ref_clk,
  input logic       rst,
  input logic [7:0] byte_data,
  input logic       byte_valid,
  input logic       byte_ready,
  input logic       bit_data,
  input logic       bit_valid,
  input logic       bit_ready,
  input logic       serial_sel
);
  logic       take;
  logic       cur_proto;
  logic       hdr_pend_q;
  logic       in_proto_q;
  logic [3:0] sync_cnt_q;
  logic [2:0] src_need_q;
  logic [2:0] pay_cnt_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  assign take      = byte_valid && byte_ready;
  assign cur_proto = hdr_pend_q ? (byte_data[1:0] == 2'h0 && byte_data != 8'h00) : in_proto_q;
  // header tracking leans on the idle cycle between packets; no gap inside one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hdr_pend_q <= 1'b1;
      in_proto_q <= 1'b0;
      sync_cnt_q <= 4'h0;
      src_need_q <= 3'h0;
      pay_cnt_q  <= 3'h0;
    end else begin
      if (!byte_valid) hdr_pend_q <= 1'b1;
      else if (take) hdr_pend_q <= 1'b0;
      if (take && hdr_pend_q) begin
        in_proto_q <= cur_proto;
        src_need_q <= {byte_data[1:0] == 2'h3, byte_data[1:0] == 2'h2, byte_data[1:0] == 2'h1};
        pay_cnt_q  <= 3'h0;
      end else if (take) pay_cnt_q <= pay_cnt_q + 3'h1;
      if (take) sync_cnt_q <= (byte_data != 8'h00) ? 4'h0 :
                              (hdr_pend_q || sync_cnt_q != 4'h0) ? sync_cnt_q + 4'h1 : 4'h0;
    end
  end
  a_byte_hold: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
    else $error("link byte changed before it was taken");
  a_bit_hold: assert property (bit_valid && !bit_ready |=> bit_valid && $stable(bit_data))
    else $error("link bit changed before it was taken");
  a_one_path: assert property (serial_sel |-> !byte_valid)
    else $error("byte path active in serial mode");
  a_path_quiet: assert property (!serial_sel |-> !bit_valid)
    else $error("bit path active in byte mode");
  a_cont_more: assert property (take && cur_proto && byte_data[7] |=> byte_valid)
    else $error("continuation set but packet ended");
  a_cont_last: assert property (take && cur_proto && !byte_data[7] |=> !byte_valid)
    else $error("continuation clear but packet went on");
  a_ovf_code: assert property (byte_valid && hdr_pend_q && byte_data[3:0] == 4'h0 &&
                               byte_data[6:4] == 3'h7 |-> byte_data == 8'h70)
    else $error("bad overflow header");
  a_proto_nibble: assert property (byte_valid && hdr_pend_q && byte_data[1:0] == 2'h0 |->
                                   byte_data[3:0] == 4'h0)
    else $error("protocol header low nibble not zero");
  a_src_len: assert property ($fell(byte_valid) && src_need_q != 3'h0 |-> pay_cnt_q == src_need_q)
    else $error("source payload length wrong");
  a_sync_form: assert property (take && sync_cnt_q != 4'h0 && byte_data != 8'h00 |->
                                byte_data == 8'h80 && sync_cnt_q >= 4'h6)
    else $error("sync pattern too short or badly ended");
endmodule : trace_link_chk

// *** verif/test_trace_packet_framer.sv ***
// bench for the framer and sink ends joined by trace_link_if
// assumes the design sources and trace_link_chk are compiled first
`timescale 1ns/1ns
module test_trace_packet_framer;
  typedef logic [7:0] bq_t[$];
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        serial_mode = 1'b0;
  logic        sync_en = 1'b0;
  logic        ts_en = 1'b0;
  logic        stim_valid = 1'b0;
  logic [4:0]  stim_port = 5'h00;
  logic [1:0]  stim_size = 2'h1;
  logic [31:0] stim_data = 32'h0;
  logic        page_wr = 1'b0;
  logic [2:0]  page_val = 3'h0;
  logic        wp_valid = 1'b0;
  logic [4:0]  wp_addr = 5'h00;
  logic [1:0]  wp_size = 2'h1;
  logic [31:0] wp_data = 32'h0;
  logic        rx_ready = 1'b1;
  logic [2:0]  page;
  logic [7:0]  rx_data, sh;
  logic        stim_ready, wp_busy, overflow_sent, busy, rx_valid, rx_head, sync_seen, bv_p;
  bq_t         wq, sq;
  logic        hq[$];
  int          ps[$];
  int          cyc, nb, n_sync, n_ovf, n_fail, cmp_count;

  always #10 ref_clk = ~ref_clk;

  trace_link_if trace_link_if_inst ();
  trace_packet_framer trace_packet_framer_inst (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .link(trace_link_if_inst),
    .serial_mode(serial_mode), .sync_en(sync_en), .ts_en(ts_en),
    .stim_valid(stim_valid), .stim_port(stim_port), .stim_size(stim_size),
    .stim_data(stim_data), .stim_ready(stim_ready), .page_wr(page_wr),
    .page_val(page_val), .page(page), .wp_valid(wp_valid), .wp_addr(wp_addr),
    .wp_size(wp_size), .wp_data(wp_data), .wp_busy(wp_busy),
    .overflow_sent(overflow_sent), .busy(busy));
  trace_sink_end trace_sink_end_inst (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .link(trace_link_if_inst),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_head(rx_head),
    .sync_seen(sync_seen));
  trace_link_chk trace_link_chk_inst (
    .ref_clk(ref_clk), .rst(rst), .byte_data(trace_link_if_inst.byte_data),
    .byte_valid(trace_link_if_inst.byte_valid), .byte_ready(trace_link_if_inst.byte_ready),
    .bit_data(trace_link_if_inst.bit_data), .bit_valid(trace_link_if_inst.bit_valid),
    .bit_ready(trace_link_if_inst.bit_ready), .serial_sel(trace_link_if_inst.serial_sel));

  // wire stream in either mode, packet start cycles on the byte path only, and the sink's user side
  always @(posedge ref_clk) begin
    cyc++;
    if (rst) nb = 0;
    if (trace_link_if_inst.byte_valid && trace_link_if_inst.byte_ready)
      wq.push_back(trace_link_if_inst.byte_data);
    if (trace_link_if_inst.bit_valid && trace_link_if_inst.bit_ready) begin
      sh = {trace_link_if_inst.bit_data, sh[7:1]};
      nb++;
      if (nb == 8) begin
        wq.push_back(sh);
        nb = 0;
      end
    end
    if (trace_link_if_inst.byte_valid && !bv_p) ps.push_back(cyc);
    bv_p = trace_link_if_inst.byte_valid;
    if (rx_valid && rx_ready) begin
      sq.push_back(rx_data);
      hq.push_back(rx_head);
    end
    if (sync_seen) n_sync++;
    if (overflow_sent) n_ovf++;
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task stuck(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    conclude();
  endtask : stuck

  task clr;
    wq.delete();
    sq.delete();
    hq.delete();
    ps.delete();
    n_sync = 0;
    n_ovf = 0;
  endtask : clr

  task do_reset(input logic ser);
    @(posedge ref_clk);
    rst <= 1'b1;
    serial_mode <= ser;
    repeat (6) @(posedge ref_clk);
    clr();
    rst <= 1'b0;
  endtask : do_reset

  task wait_sync(input int n);
    int i;
    for (i = 0; i < 5000 && n_sync < n; i++) @(posedge ref_clk);
    if (n_sync < n) stuck("sync");
  endtask : wait_sync

  // quiet means nothing on the link, nothing buffered and the sink drained
  task wait_quiet;
    int i, q;
    q = 0;
    for (i = 0; i < 3000 && q < 8; i++) begin
      @(posedge ref_clk);
      q = (busy || wp_busy || !stim_ready || rx_valid) ? 0 : q + 1;
    end
    if (q < 8) stuck("quiet");
  endtask : wait_quiet

  task send(input logic s, input logic w, input logic [4:0] a, input logic [1:0] z,
            input logic [31:0] d);
    @(posedge ref_clk);
    stim_valid <= s;
    wp_valid <= w;
    stim_port <= a;
    wp_addr <= a;
    stim_size <= z;
    wp_size <= z;
    stim_data <= d;
    wp_data <= d;
    @(posedge ref_clk);
    stim_valid <= 1'b0;
    wp_valid <= 1'b0;
  endtask : send

  function automatic bq_t src_exp(input logic w, input logic [4:0] a, input logic [1:0] z,
                                  input logic [31:0] d);
    bq_t q;
    int  i;
    q = '{{w, a, z}};
    for (i = 0; i < (z == 2'h3 ? 4 : z); i++) q.push_back(d[8*i +: 8]);
    return q;
  endfunction : src_exp

  // short form only for 1..6; long form keeps just the seven-bit groups needed
  function automatic bq_t ts_exp(input int d);
    bq_t q;
    int  v;
    if (d >= 1 && d <= 6) return '{{1'b0, 3'(d), 4'h0}};
    q = '{8'hC0};
    v = d;
    do begin
      q.push_back({1'b1, v[6:0]});
      v = v >> 7;
    end while (v != 0);
    q[$][7] = 1'b0;
    return q;
  endfunction : ts_exp

  task cmp_q(input string what, input bq_t e, input int at);
    int i;
    for (i = 0; i < e.size(); i++) check(what, e[i], wq[at+i]);
  endtask : cmp_q

  // loads d cycles apart leave d-1 in the counter: it clears on the load edge
  task ts_chk(input int at, input int d);
    cmp_q("timestamp", ts_exp(d - 1), at);
  endtask : ts_chk

  task sink_match;
    int i;
    check("sink count", wq.size(), sq.size());
    for (i = 0; i < wq.size(); i++) check("sink byte", wq[i], sq[i]);
  endtask : sink_match

  initial begin
    bq_t e;
    int  i, k;
    e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
    do_reset(1'b0);
    wait_sync(1);
    cmp_q("sync", e, 0);
    @(posedge ref_clk);
    page_wr <= 1'b1;
    page_val <= 3'h5;
    @(posedge ref_clk);
    page_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("page", 3'h5, page);
    wait_sync(2);
    #1 check("page after sync", 3'h0, page);
    cmp_q("second sync", e, 7);
    $display("test sync done");

    do_reset(1'b0);
    ts_en <= 1'b1;
    wait_sync(1);
    wait_quiet();
    clr();
    send(1'b1, 1'b0, 5'h03, 2'h1, 32'hA5);
    wait_quiet();
    repeat (150) @(posedge ref_clk);
    send(1'b1, 1'b0, 5'h01, 2'h2, 32'h1234);
    send(1'b1, 1'b0, 5'h02, 2'h1, 32'h77);
    wait_quiet();
    cmp_q("first source", src_exp(1'b0, 5'h03, 2'h1, 32'hA5), 0);
    check("ts header", 4'h0, wq[2][3:0]);
    for (i = 2; wq[i][7] === 1'b1; i++) ;
    i = i + 1;
    cmp_q("second source", src_exp(1'b0, 5'h01, 2'h2, 32'h1234), i);
    ts_chk(i + 3, ps[2] - ps[0]);
    for (i = i + 3; wq[i][7] === 1'b1; i++) ;
    i = i + 1;
    cmp_q("third source", src_exp(1'b0, 5'h02, 2'h1, 32'h77), i);
    ts_chk(i + 2, ps[4] - ps[2]);
    check("packet count", 6, ps.size());
    sink_match();
    check("header mark", 1'b1, hq[i]);
    check("payload mark", 1'b0, hq[i+1]);
    $display("test timestamp done");

    do_reset(1'b0);
    ts_en <= 1'b0;
    wait_sync(1);
    wait_quiet();
    clr();
    rx_ready <= 1'b0;
    send(1'b1, 1'b1, 5'h02, 2'h3, 32'hDEADBEEF);
    for (k = 0; k < 10; k++) begin
      #1;
      if (!stim_ready) break;
      send(1'b1, 1'b0, 5'(k), 2'h1, 32'(k));
    end
    check("buffer depth", 3, k);
    send(1'b1, 1'b0, 5'h0A, 2'h1, 32'hEE);
    send(1'b0, 1'b1, 5'h07, 2'h1, 32'h5A);
    send(1'b0, 1'b1, 5'h08, 2'h1, 32'h5B);
    rx_ready <= 1'b1;
    #1 check("slot held", 1'b1, wp_busy);
    wait_quiet();
    cmp_q("watchpoint", src_exp(1'b1, 5'h02, 2'h3, 32'hDEADBEEF), 0);
    check("overflow", 8'h70, wq[5]);
    cmp_q("held watchpoint", src_exp(1'b1, 5'h07, 2'h1, 32'h5A), 6);
    cmp_q("stimulus", src_exp(1'b0, 5'h02, 2'h3, 32'hDEADBEEF), 8);
    check("packet count", 7, ps.size());
    check("overflow pulse", 1, n_ovf);
    sink_match();
    $display("test overflow done");

    do_reset(1'b1);
    ts_en <= 1'b1;
    send(1'b1, 1'b0, 5'h1F, 2'h1, 32'h3C);
    wait_quiet();
    cmp_q("serial source", src_exp(1'b0, 5'h1F, 2'h1, 32'h3C), 0);
    check("serial ts header", 4'h0, wq[2][3:0]);
    check("serial short ts", 8'h20, wq[2]);
    check("serial sync", 0, n_sync);
    sink_match();
    $display("test serial done");
    conclude();
  end
endmodule : test_trace_packet_framer
